// >>> logic/bpt_master.sv
// Module: bus master end with parity generation/checking and transfer time-out
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/10ps
module bpt_master
  import bpt_pkg::*;
#(
  parameter int TRANSFER_TIMEOUT_US_CYC = BPT_TRANSFER_TIMEOUT_US_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  output logic irq,
  bpt_bus_if.master bus
);
  // The timer must reach its terminal count without wrapping
  if (TRANSFER_TIMEOUT_US_CYC < 1 || TRANSFER_TIMEOUT_US_CYC >= (1 << BPT_TRANSFER_TIMEOUT_US_W)) begin : g_bad_transfer_timeout_us
    $error("TRANSFER_TIMEOUT_US_CYC out of range");
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  typedef enum logic [2:0] {BPT_M_IDLE = 3'b001, BPT_M_STROBE = 3'b010, BPT_M_END = 3'b100} bpt_mstate_e;
  bpt_mstate_e state;
  bpt_mstate_e next_state;
  logic [31:0] ctrl;
  logic [BPT_AW:1] addrReg;
  logic [31:0] dataReg;
  logic [31:0] rdataReg;
  logic [BPT_STW-1:0] status;
  logic [BPT_STW-1:0] mask;
  logic [BPT_TRANSFER_TIMEOUT_US_W-1:0] timer;

  wire goPulse = regWrite && regAddr == BPT_REG_CTRL && regWdata[BPT_C_GO] && state == BPT_M_IDLE;
  wire isWrite = ctrl[BPT_C_WRITE];
  wire [1:0] aSize = ctrl[BPT_C_ASIZE +: 2];
  wire [1:0] width = ctrl[BPT_C_WIDTH +: 2];
  wire upperByte = ctrl[BPT_C_UPPER];
  wire apOpt = ctrl[BPT_C_APOPT];
  wire dpOpt = ctrl[BPT_C_DPOPT];
  wire hiDrive = ctrl[BPT_C_HIDRV];
  wire active = state == BPT_M_STROBE;

  // ----------------------------------------
  // Address parity generation
  // ----------------------------------------
  // Lines not driven float high, i.e. logic zero, so masking them is exact
  wire shortA = aSize == BPT_ASHORT;
  wire extA = aSize == BPT_AEXT;
  wire [23:1] lowMask = shortA ? (hiDrive ? 23'h7f_ffff : 23'h00_7fff) : 23'h7f_ffff;
  wire [BPT_AW:1] drvMask = extA ? {{(BPT_AW - 23){1'b1}}, lowMask} : {{(BPT_AW - 23){1'b0}}, lowMask};
  wire [BPT_AW:1] addrOut = ~(addrReg & drvMask);
  wire longN = ~(width == BPT_WLONG);
  wire [BPT_AMW-1:0] amOut = ~ctrl[BPT_C_AM +: BPT_AMW];
  wire apLow = bpt_par_n({32'h0, amOut, longN, addrOut[23:1]},
    {32'h0, {BPT_AMW{1'b1}}, 1'b1, 23'h7f_ffff});
  wire apHigh = bpt_par_n({{(64 - BPT_AW + 23){1'b1}}, addrOut[BPT_AW:24]},
    {{(64 - BPT_AW + 23){1'b0}}, {(BPT_AW - 23){1'b1}}});

  // ----------------------------------------
  // Data lanes and parity
  // ----------------------------------------
  wire [3:0] lanes = width == BPT_WLONG ? 4'hf : width == BPT_WWORD ? 4'h3 : (upperByte ? 4'h2 : 4'h1);
  wire [BPT_DW-1:0] dataOut = ~dataReg;
  logic [3:0] genPar;
  logic [3:0] rxParOk;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      genPar[i] = ^dataReg[8*i +: 8];
      rxParOk[i] = ~(^(~bus.sDataN[8*i +: 8]) ^ ~bus.sDataParityN[i]) | ~lanes[i];
    end
  end
  wire dataParErr = !isWrite && dpOpt && !bus.sDataParityValidN && !(&rxParOk);

  // ----------------------------------------
  // Bus drive
  // ----------------------------------------
  assign bus.addrN = active ? addrOut : {BPT_AW{1'b1}};
  assign bus.addrOe = active;
  assign bus.amN = active ? amOut : {BPT_AMW{1'b1}};
  assign bus.longwordSelectN = active ? longN : 1'b1;
  assign bus.strobeN = !active;
  assign bus.writeN = !(active && isWrite);
  // Undriven lines show high, the level the bus terminators give them
  wire drvAddrPar = active && apOpt;
  wire drvHighPar = drvAddrPar && extA;
  wire drvData = active && isWrite;
  wire drvDataPar = drvData && dpOpt;
  assign bus.addrParityLowN = drvAddrPar ? ~apLow : 1'b1;
  assign bus.addrParityHighN = drvHighPar ? ~apHigh : 1'b1;
  assign bus.addrParityHighOe = drvHighPar;
  assign bus.addrParityValidN = !drvAddrPar;
  assign bus.mDataN = drvData ? dataOut : {BPT_DW{1'b1}};
  assign bus.mDataOe = drvData ? lanes : 4'h0;
  assign bus.mDataParityN = drvDataPar ? ~(genPar & lanes) : 4'hf;
  assign bus.mDataParityValidN = !drvDataPar;

  // ----------------------------------------
  // Cycle sequencer and time-out
  // ----------------------------------------
  wire answered = !bus.transferAckN || !bus.busErrorN;
  // Terminal count one short, so the strobe stays low exactly TRANSFER_TIMEOUT_US_CYC cycles
  wire [BPT_TRANSFER_TIMEOUT_US_W-1:0] toutLast = TRANSFER_TIMEOUT_US_CYC[BPT_TRANSFER_TIMEOUT_US_W-1:0] - 16'h1;
  wire timedOut = active && timer == toutLast;
  always_comb begin
    case (state)
      BPT_M_IDLE: next_state = goPulse ? BPT_M_STROBE : BPT_M_IDLE;
      BPT_M_STROBE: next_state = answered || timedOut ? BPT_M_END : BPT_M_STROBE;
      BPT_M_END: next_state = answered ? BPT_M_END : BPT_M_IDLE;
      default: next_state = BPT_M_IDLE;
    endcase
  end

  // A late answer in the last timer cycle wins over the time-out
  wire evDone = active && answered;
  wire evTimeout = active && timedOut && !answered;
  wire evDataPar = active && !bus.transferAckN && dataParErr;
  wire [BPT_STW-1:0] events = {evDone, evTimeout, evDataPar, 1'b0};

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= BPT_M_IDLE;
      timer <= '0;
    end else begin
      state <= next_state;
      timer <= active ? timer + 16'h1 : '0;
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Command, address and data stay frozen while a cycle runs
  wire idle = state == BPT_M_IDLE;
  wire wrCtrl = regWrite && regAddr == BPT_REG_CTRL && idle;
  wire wrAddr = regWrite && regAddr == BPT_REG_ADDR && idle;
  wire wrData = regWrite && regAddr == BPT_REG_DATA && idle;
  wire wrMask = regWrite && regAddr == BPT_REG_MASK;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= BPT_CTRL_RST;
      addrReg <= '0;
      dataReg <= '0;
      mask <= '0;
    end else begin
      if (wrCtrl) ctrl <= regWdata;
      if (wrAddr) addrReg <= regWdata[BPT_AW:1];
      if (wrData) dataReg <= regWdata;
      if (wrMask) mask <= regWdata[BPT_STW-1:0];
    end
  end

  // ----------------------------------------
  // Status and read-back
  // ----------------------------------------
  wire statClr = regWrite && regAddr == BPT_REG_STAT;
  wire [BPT_STW-1:0] clrBits = statClr ? regWdata[BPT_STW-1:0] : {BPT_STW{1'b0}};
  wire rdCapture = active && !bus.transferAckN && !isWrite;

  // Set wins over a same-cycle clear
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      status <= '0;
      rdataReg <= '0;
    end else begin
      status <= (status & ~clrBits) | events;
      if (rdCapture) rdataReg <= ~bus.sDataN;
    end
  end

  wire [31:0] rdMux = regAddr == BPT_REG_CTRL ? {ctrl[31:1], !idle} :
    regAddr == BPT_REG_ADDR ? {addrReg, 1'b0} :
    regAddr == BPT_REG_DATA ? dataReg :
    regAddr == BPT_REG_STAT ? {28'h0, status} :
    regAddr == BPT_REG_MASK ? {28'h0, mask} :
    regAddr == BPT_REG_RDATA ? rdataReg : 32'h0;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) regRdata <= '0;
    else regRdata <= regRead ? rdMux : 32'h0;
  end

  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  assign irq = |(status & mask);
endmodule

// >>> shared/bpt_pkg.sv
// Package: constants and a parity function for the backplane parity and time-out logic
package bpt_pkg;
  localparam int BPT_AW = 31;
  localparam int BPT_DW = 32;
  localparam int BPT_AMW = 8;
  localparam int BPT_CLK_MHZ = 25;
  localparam int BPT_TRANSFER_TIMEOUT_US_US = 16;
  localparam int BPT_TRANSFER_TIMEOUT_US_CYC = BPT_TRANSFER_TIMEOUT_US_US * BPT_CLK_MHZ;
  localparam int BPT_TRANSFER_TIMEOUT_US_W = 16;
  // Address size classes
  localparam logic [1:0] BPT_ASHORT = 2'h0;
  localparam logic [1:0] BPT_ASTD = 2'h1;
  localparam logic [1:0] BPT_AEXT = 2'h2;
  // Transfer widths
  localparam logic [1:0] BPT_WBYTE = 2'h0;
  localparam logic [1:0] BPT_WWORD = 2'h1;
  localparam logic [1:0] BPT_WLONG = 2'h2;
  // Status and mask bit positions
  localparam int BPT_ST_APERR = 0;
  localparam int BPT_ST_DPERR = 1;
  localparam int BPT_ST_TRANSFER_TIMEOUT_US = 2;
  localparam int BPT_ST_DONE = 3;
  localparam int BPT_STW = 4;
  // Local register offsets
  localparam logic [3:0] BPT_REG_CTRL = 4'h0;
  localparam logic [3:0] BPT_REG_ADDR = 4'h1;
  localparam logic [3:0] BPT_REG_DATA = 4'h2;
  localparam logic [3:0] BPT_REG_STAT = 4'h3;
  localparam logic [3:0] BPT_REG_MASK = 4'h4;
  localparam logic [3:0] BPT_REG_RDATA = 4'h5;
  // Control field positions
  localparam int BPT_C_GO = 0;
  localparam int BPT_C_WRITE = 1;
  localparam int BPT_C_ASIZE = 2;
  localparam int BPT_C_WIDTH = 4;
  localparam int BPT_C_UPPER = 6;
  localparam int BPT_C_AM = 8;
  localparam int BPT_C_APOPT = 16;
  localparam int BPT_C_DPOPT = 17;
  localparam int BPT_C_HIDRV = 18;
  localparam logic [31:0] BPT_CTRL_RST = 32'h0;

  // Even parity over active-low lines: a low line counts as one
  function automatic logic bpt_par_n(input logic [63:0] linesN, input logic [63:0] used);
    bpt_par_n = ^(~linesN & used);
  endfunction
endpackage

// >>> shared/bpt_bus_if.sv
// Interface: backplane transfer bus lines between master and slave ends
`timescale 1ns/10ps
interface bpt_bus_if;
  import bpt_pkg::*;
  logic [BPT_AW:1] addrN;
  logic addrOe;
  logic [BPT_AMW-1:0] amN;
  logic longwordSelectN;
  logic strobeN;
  logic writeN;
  logic addrParityLowN;
  logic addrParityHighN;
  logic addrParityHighOe;
  logic addrParityValidN;
  logic [BPT_DW-1:0] mDataN;
  logic [3:0] mDataOe;
  logic [3:0] mDataParityN;
  logic mDataParityValidN;
  logic [BPT_DW-1:0] sDataN;
  logic [3:0] sDataOe;
  logic [3:0] sDataParityN;
  logic sDataParityValidN;
  logic transferAckN;
  logic busErrorN;
  modport master (output addrN, addrOe, amN, longwordSelectN, strobeN, writeN, addrParityLowN,
    addrParityHighN, addrParityHighOe, addrParityValidN, mDataN, mDataOe, mDataParityN,
    mDataParityValidN, input sDataN, sDataOe, sDataParityN, sDataParityValidN, transferAckN, busErrorN);
  modport slave (input addrN, addrOe, amN, longwordSelectN, strobeN, writeN, addrParityLowN,
    addrParityHighN, addrParityHighOe, addrParityValidN, mDataN, mDataOe, mDataParityN,
    mDataParityValidN, output sDataN, sDataOe, sDataParityN, sDataParityValidN, transferAckN, busErrorN);
endinterface

// >>> logic/bpt_slave.sv
// Module: bus slave end with address/data parity checking and data parity generation
`timescale 1ns/10ps
module bpt_slave
  import bpt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic addrParityOption,
  input wire logic dataParityOption,
  input wire logic extendedCapable,
  input wire logic [31:0] readData,
  output logic cycleSeen,
  output logic [BPT_AW:1] seenAddr,
  output logic [31:0] seenData,
  output logic seenWrite,
  output logic addrParityError,
  output logic dataParityError,
  input wire logic errorClear,
  bpt_bus_if.slave bus
);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire strobe = !bus.strobeN;
  wire [BPT_AW:1] addr = ~bus.addrN;
  wire [BPT_AMW-1:0] am = ~bus.amN;
  wire isLong = !bus.longwordSelectN;
  // Size class carried in the two top modifier bits of this block
  wire extA = am[BPT_AMW-1:BPT_AMW-2] == BPT_AEXT;
  wire apLowOk = !(bpt_par_n({32'h0, bus.amN, bus.longwordSelectN, bus.addrN[23:1]},
    {32'h0, {BPT_AMW{1'b1}}, 1'b1, 23'h7f_ffff}) ^ !bus.addrParityLowN);
  wire apHighOk = !(bpt_par_n({{(64 - BPT_AW + 23){1'b1}}, bus.addrN[BPT_AW:24]},
    {{(64 - BPT_AW + 23){1'b0}}, {(BPT_AW - 23){1'b1}}}) ^ !bus.addrParityHighN);
  wire addrBad = addrParityOption && !bus.addrParityValidN &&
    (!apLowOk || (extendedCapable && extA && !apHighOk));
  // No lane strobes reach the slave, so short reads answer on both low lanes
  wire [3:0] lanes = isLong ? 4'hf : 4'h3;
  logic [3:0] rxOk;
  logic [3:0] genPar;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      rxOk[i] = !(^(~bus.mDataN[8*i +: 8]) ^ !bus.mDataParityN[i]) || !bus.mDataOe[i];
      genPar[i] = ^readData[8*i +: 8];
    end
  end
  wire dataBad = dataParityOption && !bus.mDataParityValidN && !(&rxOk);
  wire rdDrive = strobe && bus.writeN;

  // ----------------------------------------
  // Response drive
  // ----------------------------------------
  assign bus.sDataN = rdDrive ? ~readData : {BPT_DW{1'b1}};
  assign bus.sDataOe = rdDrive ? lanes : 4'h0;
  assign bus.sDataParityN = rdDrive && dataParityOption ? ~(genPar & lanes) : 4'hf;
  assign bus.sDataParityValidN = !(rdDrive && dataParityOption);
  assign bus.transferAckN = !strobe;
  assign bus.busErrorN = 1'b1;

  // ----------------------------------------
  // Capture and sticky errors
  // ----------------------------------------
  logic strobeQ;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      strobeQ <= 1'b0;
      cycleSeen <= 1'b0;
      seenAddr <= '0;
      seenData <= '0;
      seenWrite <= 1'b0;
    end else begin
      strobeQ <= strobe;
      cycleSeen <= strobe && !strobeQ;
      if (strobe && !strobeQ) begin
        seenAddr <= addr;
        seenData <= ~bus.mDataN;
        seenWrite <= !bus.writeN;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      addrParityError <= 1'b0;
      dataParityError <= 1'b0;
    end else begin
      addrParityError <= (addrParityError && !errorClear) || (strobe && addrBad);
      dataParityError <= (dataParityError && !errorClear) || (strobe && dataBad);
    end
  end
endmodule

// >>> tb/bpt_sva.sv
// Checker: parity, valid-line and time-out relations on the bus between both ends
`timescale 1ns/10ps
module bpt_sva
  import bpt_pkg::*;
#(
  parameter int TRANSFER_TIMEOUT_US_CYC = BPT_TRANSFER_TIMEOUT_US_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [BPT_AW:1] addrN,
  input wire logic addrOe,
  input wire logic [BPT_AMW-1:0] amN,
  input wire logic longwordSelectN,
  input wire logic strobeN,
  input wire logic addrParityLowN,
  input wire logic addrParityHighN,
  input wire logic addrParityHighOe,
  input wire logic addrParityValidN,
  input wire logic [BPT_DW-1:0] mDataN,
  input wire logic [3:0] mDataOe,
  input wire logic [3:0] mDataParityN,
  input wire logic mDataParityValidN,
  input wire logic [BPT_DW-1:0] sDataN,
  input wire logic [3:0] sDataOe,
  input wire logic [3:0] sDataParityN,
  input wire logic sDataParityValidN,
  input wire logic transferAckN
);
  // Slack of two cycles for the strobe launch and release edges
  localparam int TMAX = TRANSFER_TIMEOUT_US_CYC + 2;
  function automatic logic lanesOk(input logic [31:0] d, input logic [3:0] p, input logic [3:0] oe);
    lanesOk = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (oe[i] && ((^(~d[i*8+:8])) ^ ~p[i])) begin
        lanesOk = 1'b0;
      end
    end
  endfunction
  wire lowGrp = ^(~{amN, addrN[23:1], longwordSelectN});
  wire highGrp = ^(~addrN[31:24]);
  wire mOk = lanesOk(mDataN, mDataParityN, mDataOe);
  wire sOk = lanesOk(sDataN, sDataParityN, sDataOe);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  addr_low_par_a: assert property (!strobeN && !addrParityValidN |-> addrParityLowN == ~lowGrp)
    else $error("lower address parity wrong");
  addr_high_par_a: assert property (!addrParityValidN && addrParityHighOe |-> addrParityHighN == ~highGrp)
    else $error("upper address parity wrong");
  high_ext_only_a: assert property (!strobeN && addrParityHighOe |-> ~amN[7:6] == BPT_AEXT)
    else $error("upper parity driven outside extended cycle");
  aval_with_addr_a: assert property (!addrParityValidN |-> addrOe && !strobeN)
    else $error("address parity valid without address");
  apar_idle_a: assert property (addrParityValidN |-> addrParityLowN && addrParityHighN)
    else $error("address parity driven while not valid");
  mdata_par_a: assert property (!mDataParityValidN |-> mOk)
    else $error("master data parity wrong");
  sdata_par_a: assert property (!sDataParityValidN |-> sOk)
    else $error("slave data parity wrong");
  lane_set_a: assert property (!mDataParityValidN |-> mDataOe inside {4'h1, 4'h2, 4'h3, 4'hf})
    else $error("data lanes do not match a transfer width");
  dpar_idle_a: assert property (mDataParityValidN |-> mDataParityN == 4'hf)
    else $error("data parity driven while not valid");
  ack_end_a: assert property (!strobeN && !transferAckN |-> ##[1:2] strobeN)
    else $error("strobe held after acknowledge");
  strobe_bound_a: assert property ($fell(strobeN) |-> ##[1:TMAX] strobeN)
    else $error("strobe held past time-out");
endmodule

// >>> tb/test_bus_parity_and_transfer_timeout.sv
// Testbench: master and slave ends joined, plus a second master facing a silent bus
`timescale 1ns/10ps
module test_bus_parity_and_transfer_timeout;
  import bpt_pkg::*;
  localparam int TRANSFER_TIMEOUT_US = 20;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic apOpt = 1'b0;
  logic dpOpt = 1'b0;
  logic extCap = 1'b0;
  logic errorClear = 1'b0;
  logic [31:0] readData = 32'h0;
  logic [31:0] regRdata, regRdata2, seenData, rd2, s;
  logic [BPT_AW:1] seenAddr;
  logic irq, irq2, cycleSeen, seenWrite, addrParityError, dataParityError;
  logic mskD = 1'b0;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int lowCnt = 0;
  int seenCnt = 0;
  bpt_bus_if bus ();
  bpt_bus_if bus2 ();
  bpt_master #(.TRANSFER_TIMEOUT_US_CYC(TRANSFER_TIMEOUT_US)) u_bpt_master (.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .irq(irq), .bus(bus));
  bpt_master #(.TRANSFER_TIMEOUT_US_CYC(TRANSFER_TIMEOUT_US)) u_bpt_master_2 (.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata2), .irq(irq2), .bus(bus2));
  bpt_slave u_bpt_slave (.ref_clk(ref_clk), .nrst(nrst), .addrParityOption(apOpt), .dataParityOption(dpOpt),
    .extendedCapable(extCap), .readData(readData), .cycleSeen(cycleSeen), .seenAddr(seenAddr),
    .seenData(seenData), .seenWrite(seenWrite), .addrParityError(addrParityError),
    .dataParityError(dataParityError), .errorClear(errorClear), .bus(bus));
  bpt_sva #(.TRANSFER_TIMEOUT_US_CYC(TRANSFER_TIMEOUT_US)) u_bpt_sva (.ref_clk(ref_clk), .nrst(nrst), .addrN(bus.addrN), .addrOe(bus.addrOe),
    .amN(bus.amN), .longwordSelectN(bus.longwordSelectN), .strobeN(bus.strobeN),
    .addrParityLowN(bus.addrParityLowN), .addrParityHighN(bus.addrParityHighN),
    .addrParityHighOe(bus.addrParityHighOe), .addrParityValidN(bus.addrParityValidN), .mDataN(bus.mDataN),
    .mDataOe(bus.mDataOe), .mDataParityN(bus.mDataParityN), .mDataParityValidN(bus.mDataParityValidN),
    .sDataN(bus.sDataN), .sDataOe(bus.sDataOe), .sDataParityN(bus.sDataParityN),
    .sDataParityValidN(bus.sDataParityValidN), .transferAckN(bus.transferAckN));
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (bus2.strobeN === 1'b0) lowCnt++;
  always @(posedge ref_clk) if (cycleSeen === 1'b1) seenCnt++;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // A spare edge after each strobe keeps two writes of one signal out of one time step
  task automatic regW(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic regR(input logic [3:0] a, output logic [31:0] d);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    @(posedge ref_clk);
    d = regRdata;
    rd2 = regRdata2;
  endtask
  // Address lines a cycle of this size carries; the rest float to logic zero
  function automatic logic [31:1] expAddr(input logic [31:0] c, input logic [31:1] a);
    expAddr = a;
    if (c[3:2] != BPT_AEXT) expAddr[31:24] = 8'h0;
    if (c[3:2] == BPT_ASHORT && !c[BPT_C_HIDRV]) expAddr[23:16] = 8'h0;
  endfunction
  task automatic xfer(input logic [31:0] c, input logic [31:1] a, input logic [31:0] d);
    logic [31:0] t;
    int n0;
    t = 32'h0;
    n0 = seenCnt;
    regW(BPT_REG_ADDR, {a, 1'b0});
    regW(BPT_REG_DATA, d);
    regW(BPT_REG_CTRL, c);
    for (int i = 0; i < 40 && t[BPT_ST_DONE] !== 1'b1; i++) regR(BPT_REG_STAT, t);
    check(t & 32'hf, 32'h8);
    check({30'h0, addrParityError, dataParityError}, 32'h0);
    check(seenCnt - n0, 32'h1);
    errorClear <= 1'b1;
    @(posedge ref_clk);
    errorClear <= 1'b0;
    check({31'h0, seenWrite}, {31'h0, c[1]});
    check({31'h0, irq}, {31'h0, mskD});
    check({1'b0, seenAddr}, {1'b0, expAddr(c, a)});
    if (c[5:4] == BPT_WLONG && c[1]) check(seenData, d);
    if (c[5:4] == BPT_WLONG && !c[1]) begin
      regR(BPT_REG_RDATA, t);
      check(t, readData);
    end
    regW(BPT_REG_STAT, 32'hf);
    regR(BPT_REG_STAT, t);
    check(t, 32'h0);
    check({31'h0, irq}, 32'h0);
  endtask
  initial begin
    logic [31:0] c;
    bus2.sDataN = '1;
    bus2.sDataOe = 4'h0;
    bus2.sDataParityN = 4'hf;
    bus2.sDataParityValidN = 1'b1;
    bus2.transferAckN = 1'b1;
    bus2.busErrorN = 1'b1;
    void'($urandom(44115));
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    // Extended longword write; the second master sees no answer and must time out
    apOpt <= 1'b1;
    dpOpt <= 1'b1;
    extCap <= 1'b1;
    xfer(32'h3802b, 31'h5a5a_c3c3, 32'h8142_7e18);
    for (int i = 0; i < 60 && bus2.strobeN !== 1'b1; i++) @(posedge ref_clk);
    check({31'h0, lowCnt >= TRANSFER_TIMEOUT_US && lowCnt <= TRANSFER_TIMEOUT_US + 2}, 32'h1);
    check({28'h0, bus2.mDataOe}, 32'h0);
    check({31'h0, bus2.addrOe}, 32'h0);
    regR(BPT_REG_STAT, s);
    check(rd2 & 32'h4, 32'h4);
    regW(BPT_REG_MASK, 32'hc);
    check({30'h0, irq2, irq}, 32'h2);
    regR(4'hf, s);
    check(s, 32'h0);
    $display("test time-out done");
    mskD = 1'b1;
    for (int k = 0; k < 30; k++) begin
      c = $urandom & 32'h7ffff;
      c[0] = 1'b1;
      c[3:2] = c[3:2] % 3;
      c[5:4] = c[5:4] % 3;
      c[15:14] = c[3:2];
      {apOpt, dpOpt, extCap} <= 3'($urandom);
      readData <= $urandom;
      xfer(c, 31'($urandom), $urandom);
    end
    $display("test random transfers done");
    test_done();
  end
endmodule
